// File: hw/dhif_front_end.sv
// host interface front end: parallel, serial and two-wire ports into one byte stream
// Functional notes
// - three straps select 6800, 8080, 4-wire, 3-wire or two-wire port.
// - serial and two-wire modes never drive data pads seven down to two.
// - 6800 direction high reads RAM or status, low writes RAM or command.
// - 6800 enable high with chip select low latches a transfer.
// - 8080 read strobe low with chip select low latches a read.
// - 8080 write strobe low with chip select low latches a write.
// - data/command select high means RAM data, low means status or command.
// - 4-wire mode shifts serial input msb first on rising serial clock.
// - 4-wire byte and data/command select taken on eighth clock.
// - chip select high holds serial receiver idle, clocks ignored.
// - falling chip select starts a serial transfer.
// - serial receiver also works with chip select held low.
// - deselected device clears the serial shift register and bit counter; two-wire state ignores chip select.
// - serial modes are write only, no read path.
// - 3-wire mode shifts nine bits: flag, then data seven down to zero.
// - 3-wire first bit routes byte to RAM when one, command when zero.
// - two-wire port is slave only, accepts writes, returns status or RAM.
// - two-wire transfers begin only from idle bus, both lines high.
// - answers two addresses differing in last bit, taken from strap.
// - control bytes carry continuation and data/command flags.
// - two-wire read returns data after address, stops on master nack.
module dhif_front_end
    import dhif_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [2:0] interface_mode_straps,
    input wire logic cs_n,
    input wire logic data_command_select,
    input wire logic rd_e,
    input wire logic wr_rw,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output dhif_byte_type rx_byte,
    output logic rx_valid,
    output dhif_rdreq_type rd_req,
    output logic rd_req_valid,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] status_in,
    output dhif_mode_type mode
);

    // ****************************************
    // input conditioning
    // ****************************************
    dhif_pins_type pins;
    logic [2:0] straps_s;
    dhif_pins_type pins_raw;

    assign pins_raw = '{cs_n: cs_n, dc: data_command_select, rd: rd_e, wr: wr_rw,
                        d1: pad_in[1], d0: pad_in[0]};

    dhif_sync #(.WIDTH(6), .INIT(6'h3f)) u_sync_pins (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    // only d7..d2 of the parallel bus go through the filter separately
    logic [5:0] dhi_s;
    dhif_sync #(.WIDTH(6), .INIT(6'h00)) u_sync_dhi (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(pad_in[7:2]),
        .sync_out(dhi_s)
    );

    dhif_sync #(.WIDTH(3), .INIT(3'h0)) u_sync_straps (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(interface_mode_straps),
        .sync_out(straps_s)
    );

    logic [7:0] pbus;
    assign pbus = {dhi_s, pins.d1, pins.d0};

    // ****************************************
    // mode decode
    // ****************************************
    function automatic dhif_mode_type decode_mode(input logic [2:0] s);
        unique case (s)
            STRAP_6800: decode_mode = DHIF_MODE_6800;
            STRAP_8080: decode_mode = DHIF_MODE_8080;
            STRAP_SPI4: decode_mode = DHIF_MODE_SPI4;
            STRAP_SPI3: decode_mode = DHIF_MODE_SPI3;
            STRAP_TWI: decode_mode = DHIF_MODE_TWI;
            default: decode_mode = DHIF_MODE_NONE;
        endcase
    endfunction

    dhif_mode_type mode_ff, nxt_mode;
    assign nxt_mode = decode_mode(straps_s);

    // previous samples for edge finding
    dhif_pins_type prev_ff;
    logic scl_rise, scl_fall, sda_rise, sda_fall, cs_fall, sel;
    assign scl_rise = pins.d0 & ~prev_ff.d0;
    assign scl_fall = ~pins.d0 & prev_ff.d0;
    assign sda_rise = pins.d1 & ~prev_ff.d1;
    assign sda_fall = ~pins.d1 & prev_ff.d1;
    assign cs_fall = ~pins.cs_n & prev_ff.cs_n;
    assign sel = ~pins.cs_n;

    // parallel strobe activity: 6800 enable high, 8080 strobes low
    logic p_act, p_act_prev_ff, p_read, p_read_ff;
    always_comb begin
        p_act = 1'b0;
        p_read = 1'b0;
        if (mode_ff == DHIF_MODE_6800) begin
            p_act = sel & pins.rd;
            p_read = pins.wr;
        end else if (mode_ff == DHIF_MODE_8080) begin
            p_act = sel & (~pins.rd | ~pins.wr);
            p_read = ~pins.rd;
        end
    end

    // ****************************************
    // serial receiver
    // ****************************************
    logic spi_mode, spi_clear, spi_done;
    logic [8:0] sh;
    logic [3:0] cnt;
    logic [3:0] nbits;
    logic [8:0] sh_nxt_view;
    assign spi_mode = (mode_ff == DHIF_MODE_SPI4) | (mode_ff == DHIF_MODE_SPI3);
    assign nbits = (mode_ff == DHIF_MODE_SPI3) ? SPI3_BITS : SPI4_BITS;
    // byte completes on the last rising clock; value is shreg with the new bit
    assign spi_done = spi_mode & sel & ~cs_fall & scl_rise & (cnt == nbits - 4'h1);
    assign sh_nxt_view = {sh[7:0], pins.d1};
    // deselect, a fresh falling chip select or a finished byte restarts the count,
    // so a host that keeps chip select low still streams bytes back to back
    assign spi_clear = ~spi_mode | ~sel | cs_fall | spi_done;

    dhif_shift #(.WIDTH(9)) u_shift (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(spi_clear),
        .shift_en(scl_rise & sel & spi_mode),
        .bit_in(pins.d1),
        .shreg(sh),
        .count(cnt)
    );

    // ****************************************
    // two-wire slave
    // ****************************************
    typedef enum {TW_IDLE, TW_ADDR, TW_ACK, TW_CTRL, TW_DATA, TW_TX, TW_TXACK, TW_SKIP} dhif_tw_type;
    dhif_tw_type tw_ff, nxt_tw, after_ack_ff, nxt_after_ack;
    logic [7:0] tsh_ff, nxt_tsh;
    logic [3:0] tcnt_ff, nxt_tcnt;
    logic cont_ff, nxt_cont, twdc_ff, nxt_twdc, rdc_ff, nxt_rdc, sda_oe_ff, nxt_sda_oe;
    logic tw_mode, tw_start, tw_stop;
    assign tw_mode = mode_ff == DHIF_MODE_TWI;
    assign tw_start = tw_mode & pins.d0 & prev_ff.d0 & sda_fall;
    assign tw_stop = tw_mode & pins.d0 & prev_ff.d0 & sda_rise;

    // ****************************************
    // output and delivery logic
    // ****************************************
    dhif_byte_type rx_ff, nxt_rx;
    logic rxv_ff, nxt_rxv, rqv_ff, nxt_rqv, rq_dc_ff, nxt_rq_dc;
    logic [7:0] pout_ff, nxt_pout, poe_ff, nxt_poe;

    // one process for all groups: two-wire, delivery, pads
    always_comb begin
        nxt_tw = tw_ff;
        nxt_after_ack = after_ack_ff;
        nxt_tsh = tsh_ff;
        nxt_tcnt = tcnt_ff;
        nxt_cont = cont_ff;
        nxt_twdc = twdc_ff;
        nxt_rdc = rdc_ff;
        nxt_sda_oe = sda_oe_ff;
        nxt_rx = rx_ff;
        nxt_rxv = 1'b0;
        nxt_rqv = 1'b0;
        nxt_rq_dc = rq_dc_ff;
        nxt_pout = pout_ff;
        nxt_poe = 8'h00;
        // parallel: latch on strobe release edge of activity
        if (!p_act && p_act_prev_ff && !p_read_ff) begin
            nxt_rx = '{is_data: pins.dc, value: pbus};
            nxt_rxv = 1'b1;
        end
        if (p_act && !p_act_prev_ff && p_read) begin
            nxt_rqv = 1'b1; // core returns the pipelined byte
            nxt_rq_dc = pins.dc;
        end
        if (p_act && p_read) begin
            nxt_poe = 8'hff;
            nxt_pout = pins.dc ? rd_data : status_in;
        end
        // serial byte hand-off
        if (spi_done) begin
            if (mode_ff == DHIF_MODE_SPI3) begin
                nxt_rx = '{is_data: sh[7], value: sh_nxt_view[7:0]};
            end else begin
                nxt_rx = '{is_data: pins.dc, value: sh_nxt_view[7:0]};
            end
            nxt_rxv = 1'b1;
        end
        // two-wire: change outputs after scl falls, sample on rise
        if (!tw_mode || tw_stop) begin
            nxt_tw = TW_IDLE;
            nxt_sda_oe = 1'b0;
        end else if (tw_start) begin
            nxt_tw = TW_ADDR;
            nxt_tcnt = 4'h0;
            nxt_sda_oe = 1'b0;
        end else begin
            unique case (tw_ff)
                TW_IDLE, TW_SKIP: begin
                end
                TW_ADDR, TW_CTRL, TW_DATA: begin
                    if (scl_rise) begin
                        nxt_tsh = {tsh_ff[6:0], pins.d1};
                        nxt_tcnt = tcnt_ff + 4'h1;
                    end
                    if (scl_fall && tcnt_ff == TWI_ACK_BIT) begin
                        nxt_tcnt = 4'h0;
                        nxt_tw = TW_ACK;
                        nxt_sda_oe = 1'b1;
                        nxt_after_ack = TW_CTRL;
                        if (tw_ff == TW_ADDR) begin
                            // address strap rides the data/command pin
                            if (tsh_ff[7:1] != {TWI_ADDR_HI, pins.dc}) begin
                                nxt_tw = TW_SKIP;
                                nxt_sda_oe = 1'b0;
                            end else if (tsh_ff[0]) begin
                                nxt_after_ack = TW_TX;
                                nxt_rqv = 1'b1;
                                nxt_rq_dc = rdc_ff;
                            end
                        end else if (tw_ff == TW_CTRL) begin
                            nxt_cont = tsh_ff[CTRL_CONT_BIT];
                            nxt_twdc = tsh_ff[CTRL_DC_BIT];
                            nxt_rdc = tsh_ff[CTRL_DC_BIT];
                            nxt_after_ack = TW_DATA;
                        end else begin
                            nxt_rx = '{is_data: twdc_ff, value: tsh_ff};
                            nxt_rxv = 1'b1;
                            nxt_after_ack = cont_ff ? TW_CTRL : TW_DATA;
                        end
                    end
                end
                TW_ACK: begin
                    if (scl_fall) begin
                        nxt_tw = after_ack_ff;
                        nxt_sda_oe = 1'b0;
                        nxt_tsh = (after_ack_ff == TW_TX) ? (rq_dc_ff ? rd_data : status_in) : tsh_ff;
                        if (after_ack_ff == TW_TX) begin
                            nxt_sda_oe = ~nxt_tsh[7];
                        end
                    end
                end
                TW_TX: begin
                    if (scl_fall) begin
                        nxt_tcnt = tcnt_ff + 4'h1;
                        nxt_tsh = {tsh_ff[6:0], 1'b1};
                        nxt_sda_oe = (tcnt_ff == 4'h7) ? 1'b0 : ~tsh_ff[6];
                        if (tcnt_ff == 4'h7) begin
                            nxt_tw = TW_TXACK;
                        end
                    end
                end
                TW_TXACK: begin
                    if (scl_rise) begin
                        nxt_tcnt = 4'h0;
                        if (pins.d1) begin
                            nxt_tw = TW_SKIP;
                        end else begin
                            nxt_tw = TW_ACK;
                            nxt_after_ack = TW_TX;
                            nxt_rqv = 1'b1;
                        end
                    end
                end
            endcase
        end
        // serial modes leave d7..d2 undriven and have no read path
        if (tw_mode) begin
            nxt_poe = {6'h00, nxt_sda_oe, 1'b0};
            nxt_pout = 8'h00; // open drain pulls low
        end else if (spi_mode) begin
            nxt_poe = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_ff <= DHIF_MODE_NONE;
            prev_ff <= '1;
            p_act_prev_ff <= 1'b0;
            p_read_ff <= 1'b0;
            tw_ff <= TW_IDLE;
            after_ack_ff <= TW_CTRL;
            tsh_ff <= 8'h00;
            tcnt_ff <= 4'h0;
            cont_ff <= 1'b0;
            twdc_ff <= 1'b0;
            rdc_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            rx_ff <= '0;
            rxv_ff <= 1'b0;
            rqv_ff <= 1'b0;
            rq_dc_ff <= 1'b0;
            pout_ff <= STATUS_RESET;
            poe_ff <= 8'h00;
        end else begin
            mode_ff <= nxt_mode;
            prev_ff <= pins;
            p_act_prev_ff <= p_act;
            p_read_ff <= p_read;
            tw_ff <= nxt_tw;
            after_ack_ff <= nxt_after_ack;
            tsh_ff <= nxt_tsh;
            tcnt_ff <= nxt_tcnt;
            cont_ff <= nxt_cont;
            twdc_ff <= nxt_twdc;
            rdc_ff <= nxt_rdc;
            sda_oe_ff <= nxt_sda_oe;
            rx_ff <= nxt_rx;
            rxv_ff <= nxt_rxv;
            rqv_ff <= nxt_rqv;
            rq_dc_ff <= nxt_rq_dc;
            pout_ff <= nxt_pout;
            poe_ff <= nxt_poe;
        end
    end

    assign rx_byte = rx_ff;
    assign rx_valid = rxv_ff;
    assign rd_req = '{is_data: rq_dc_ff};
    assign rd_req_valid = rqv_ff;
    assign pad_out = pout_ff;
    assign pad_oe = poe_ff;
    assign mode = mode_ff;

    // ****************************************
    // assertions
    // ****************************************
    property p_hi_pads_quiet;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode_ff inside {DHIF_MODE_SPI4, DHIF_MODE_SPI3, DHIF_MODE_TWI}) |=> pad_oe[7:2] == 6'h00;
    endproperty
    a_hi_pads_quiet: assert property (p_hi_pads_quiet) else $error("upper pads driven");

    property p_spi_no_read;
        @(posedge ref_clk) disable iff (sys_rst)
        spi_mode |=> pad_oe == 8'h00;
    endproperty
    a_spi_no_read: assert property (p_spi_no_read) else $error("serial mode drove pads");

    property p_spi_idle;
        @(posedge ref_clk) disable iff (sys_rst)
        (spi_mode && !sel) |=> cnt == 4'h0 && !rx_valid;
    endproperty
    a_spi_idle: assert property (p_spi_idle) else $error("serial not idle when deselected");

    property p_spi_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        !sel |=> sh == 9'h000;
    endproperty
    a_spi_clear: assert property (p_spi_clear) else $error("shift register kept");

    property p_spi4_byte;
        @(posedge ref_clk) disable iff (sys_rst)
        (spi_done && mode_ff == DHIF_MODE_SPI4) |=>
            rx_valid && rx_byte.is_data == $past(pins.dc) && rx_byte.value == $past(sh_nxt_view[7:0]);
    endproperty
    a_spi4_byte: assert property (p_spi4_byte) else $error("4-wire byte wrong");

    property p_spi3_flag;
        @(posedge ref_clk) disable iff (sys_rst)
        (spi_done && mode_ff == DHIF_MODE_SPI3) |=> rx_valid && rx_byte.is_data == $past(sh[7]);
    endproperty
    a_spi3_flag: assert property (p_spi3_flag) else $error("3-wire flag wrong");

    property p_6800_read_drive;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode_ff == DHIF_MODE_6800 && sel && pins.rd && pins.wr) |=> pad_oe == 8'hff;
    endproperty
    a_6800_read_drive: assert property (p_6800_read_drive) else $error("6800 read not driven");

    property p_8080_write;
        @(posedge ref_clk) disable iff (sys_rst)
        (mode_ff == DHIF_MODE_8080 && !p_act && p_act_prev_ff && !p_read_ff) |=>
            rx_valid && rx_byte.is_data == $past(pins.dc);
    endproperty
    a_8080_write: assert property (p_8080_write) else $error("8080 write lost");

    property p_rx_pulse;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_valid |=> !rx_valid;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("byte strobe too long");

    c_spi4: cover property (@(posedge ref_clk) disable iff (sys_rst) spi_done && mode_ff == DHIF_MODE_SPI4);
    c_spi3: cover property (@(posedge ref_clk) disable iff (sys_rst) spi_done && mode_ff == DHIF_MODE_SPI3);
    c_twi_rx: cover property (@(posedge ref_clk) disable iff (sys_rst) tw_mode && rx_valid);
    c_par_rd: cover property (@(posedge ref_clk) disable iff (sys_rst) rd_req_valid && !tw_mode);

endmodule // dhif_front_end

// File: hw/dhif_shift.sv
// serial shift register with bit counter, cleared while deselected
module dhif_shift
    import dhif_pkg::*;
#(
    parameter int WIDTH = 9
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic shift_en,
    input wire logic bit_in,
    output logic [WIDTH-1:0] shreg,
    output logic [3:0] count
);

    logic [WIDTH-1:0] sh_ff, nxt_sh;
    logic [3:0] cnt_ff, nxt_cnt;

    // msb first; clear returns to initial state
    always_comb begin
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        if (clear) begin
            nxt_sh = '0;
            nxt_cnt = 4'h0;
        end else if (shift_en) begin
            nxt_sh = {sh_ff[WIDTH-2:0], bit_in};
            nxt_cnt = cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sh_ff <= '0;
            cnt_ff <= 4'h0;
        end else begin
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
        end
    end

    assign shreg = sh_ff;
    assign count = cnt_ff;

endmodule // dhif_shift

// File: hw/dhif_sync.sv
// three-stage input synchroniser with agreement filter
module dhif_sync
    import dhif_pkg::*;
#(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
    logic [WIDTH-1:0] nxt_out;

    // a change counts only once stages two and three agree
    always_comb begin
        nxt_out = out_ff;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
                nxt_out[i] = s3_ff[i];
            end
        end
    end

    // s1 feeds s2 only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_ff <= INIT;
            s2_ff <= INIT;
            s3_ff <= INIT;
            out_ff <= INIT;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign sync_out = out_ff;

endmodule // dhif_sync

// File: shared/dhif_pkg.sv
// package for the display host interface front end: modes, carriers, constants
package dhif_pkg;

    // ****************************************
    // mode selection
    // ****************************************
    // strap code read as {ms0, ms1, ms2}
    localparam logic [2:0] STRAP_6800 = 3'h1;
    localparam logic [2:0] STRAP_8080 = 3'h3;
    localparam logic [2:0] STRAP_SPI4 = 3'h0;
    localparam logic [2:0] STRAP_SPI3 = 3'h4;
    localparam logic [2:0] STRAP_TWI = 3'h2;

    typedef enum {
        DHIF_MODE_6800,
        DHIF_MODE_8080,
        DHIF_MODE_SPI4,
        DHIF_MODE_SPI3,
        DHIF_MODE_TWI,
        DHIF_MODE_NONE
    } dhif_mode_type;

    // ****************************************
    // constants
    // ****************************************
    localparam logic [5:0] TWI_ADDR_HI = 6'h1e; // upper six address bits 011110
    localparam int CTRL_CONT_BIT = 7;
    localparam int CTRL_DC_BIT = 6;
    localparam logic [3:0] SPI4_BITS = 4'h8;
    localparam logic [3:0] SPI3_BITS = 4'h9;
    localparam logic [3:0] TWI_ACK_BIT = 4'h8;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ****************************************
    // carriers
    // ****************************************
    // byte delivered to the core
    typedef struct packed {
        logic is_data;
        logic [7:0] value;
    } dhif_byte_type;

    // synchronised host pins
    typedef struct packed {
        logic cs_n;
        logic dc;
        logic rd;
        logic wr;
        logic d1;
        logic d0;
    } dhif_pins_type;

    // read request to the core
    typedef struct packed {
        logic is_data;
    } dhif_rdreq_type;

endpackage : dhif_pkg

// File: tb/dhif_host_model.sv
// host model: drives chip select, select pin, strobes and pads as the host would
module dhif_host_model
    import dhif_pkg::*;
(
    input wire logic ref_clk,
    output logic cs_n,
    output logic dc,
    output logic rd_e,
    output logic wr_rw,
    output logic [7:0] pad
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // host transfers
    // ****************************************
    initial begin
        cs_n = 1'b1;
        dc = 1'b0;
        rd_e = 1'b1;
        wr_rw = 1'b1;
        pad = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // unused strobes rest at a fixed level, never floating
    task automatic idle(input logic m68);
        rd_e <= ~m68;
        wr_rw <= 1'b1;
    endtask
    // serial frame; the link clock runs at 125 ns, unrelated to the core clock
    task automatic spi(input logic [8:0] bits, input int n, input logic a0, input logic sel);
        cs_n <= ~sel;
        dc <= a0;
        tick(8);
        for (int i = n - 1; i >= 0; i--) begin
            pad[0] <= 1'b0;
            pad[1] <= bits[i];
            #62.5;
            pad[0] <= 1'b1;
            #62.5;
        end
        pad[0] <= 1'b0;
        tick(8);
        cs_n <= 1'b1;
        pad[1] <= ~pad[1]; // data no longer held: show the inverse, not the last bit
        tick(8);
    endtask
    // parallel access; on a read the pads are released and carry a changing pattern
    task automatic par(input logic m68, input logic rd, input logic a0, input logic [7:0] d);
        cs_n <= 1'b0;
        dc <= a0;
        pad <= rd ? ~pad : d;
        if (m68) wr_rw <= rd;
        tick(2);
        if (m68) rd_e <= 1'b1;
        else if (rd) rd_e <= 1'b0;
        else wr_rw <= 1'b0;
        tick(8);
        idle(m68);
        tick(2);
        cs_n <= 1'b1;
        tick(8);
    endtask
    // two-wire write from an idle bus; every ninth bit is released for the ack
    task automatic twi(input logic [26:0] bits);
        cs_n <= 1'b0;
        dc <= 1'b0;
        pad[1:0] <= 2'b11;
        tick(8);
        pad[1] <= 1'b0;
        tick(8);
        for (int i = 26; i >= 0; i--) begin
            pad[0] <= 1'b0;
            tick(4);
            pad[1] <= bits[i];
            tick(4);
            pad[0] <= 1'b1;
            tick(8);
        end
        pad[0] <= 1'b0;
        tick(4);
        pad[1] <= 1'b0;
        tick(4);
        pad[0] <= 1'b1;
        tick(8);
        pad[1] <= 1'b1; // stop while the clock is high
        tick(8);
    endtask
endmodule // dhif_host_model

// File: tb/display_host_interface_front_end_tb_top.sv
// testbench for the host interface front end, all five ports
module display_host_interface_front_end_tb_top
    import dhif_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] straps = STRAP_SPI4;
    logic cs_n, dcs, rd_e, wr_rw, rx_valid, rd_req_valid;
    logic [7:0] host_pad, pad_in, pad_out, pad_oe, rd_data = 8'h00, status_in = 8'h00, d;
    logic a;
    dhif_byte_type rx_byte;
    dhif_rdreq_type rd_req;
    dhif_mode_type mode;
    logic [8:0] exp_q[$];
    logic [2:0] codes[5] = '{STRAP_6800, STRAP_8080, STRAP_SPI4, STRAP_SPI3, STRAP_TWI};
    int err_count = 0, tests_run = 0, cyc = 0, rq_cnt = 0;
    // ****************************************
    // clock, wiring, checks
    // ****************************************
    always #5 ref_clk = ~ref_clk;
    // a pad shows the device where it drives, else the host
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & host_pad);
    dhif_host_model u_dhif_host_model (.ref_clk(ref_clk), .cs_n(cs_n), .dc(dcs), .rd_e(rd_e),
        .wr_rw(wr_rw), .pad(host_pad));
    dhif_front_end u_dhif_front_end (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .interface_mode_straps(straps), .cs_n(cs_n), .data_command_select(dcs), .rd_e(rd_e),
        .wr_rw(wr_rw), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rd_req(rd_req), .rd_req_valid(rd_req_valid), .rd_data(rd_data),
        .status_in(status_in), .mode(mode));
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // every delivered byte must be the oldest one still expected; read requests are counted
    always @(posedge ref_clk) begin
        if (rx_valid === 1'b1) begin
            chk("rx_byte", rx_byte, exp_q.size() ? exp_q.pop_front() : ~rx_byte);
        end
        if (rd_req_valid === 1'b1) rq_cnt++;
    end
    // hang guard, well above the length of the sequence
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            stop_test();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h17ff3cf1));
        tick(6);
        sys_rst <= 1'b0;
        tick(1);
        chk("oe_reset", {1'b0, pad_oe}, 9'h000);
        foreach (codes[i]) begin
            straps <= codes[i];
            u_dhif_host_model.idle(i == 0);
            tick(12);
            chk("mode", 9'(mode), 9'(i));
            if (i >= 2) chk("oe_serial", {1'b0, pad_oe}, 9'h000);
        end
        straps <= STRAP_SPI4;
        tick(12);
        u_dhif_host_model.spi(9'h1ff, 8, 1'b1, 1'b0); // clocks while deselected: no byte
        u_dhif_host_model.spi(9'($urandom), 3, 1'b0, 1'b1); // partial byte dropped on deselect
        for (int k = 0; k < 6; k++) begin
            d = 8'($urandom);
            a = 1'($urandom);
            if (k < 4) exp_q.push_back({a, d});
            else exp_q.push_back({a, d});
            if (k == 4) straps <= STRAP_SPI3;
            if (k == 4) tick(12);
            if (k < 4) u_dhif_host_model.spi({1'b0, d}, 8, a, 1'b1);
            else u_dhif_host_model.spi({a, d}, 9, 1'b0, 1'b1);
            chk("oe_spi", {1'b0, pad_oe}, 9'h000);
        end
        for (int m = 0; m < 2; m++) begin
            straps <= m ? STRAP_6800 : STRAP_8080;
            u_dhif_host_model.idle(m[0]);
            tick(12);
            for (int k = 0; k < 2; k++) begin
                d = 8'($urandom);
                exp_q.push_back({k[0], d});
                u_dhif_host_model.par(m[0], 1'b0, k[0], d);
                rd_data <= 8'($urandom);
                status_in <= 8'($urandom);
                // a display data read needs one dummy read ahead of it
                if (k == 1) u_dhif_host_model.par(m[0], 1'b1, 1'b1, 8'h00);
                fork
                    u_dhif_host_model.par(m[0], 1'b1, k[0], 8'h00);
                    begin
                        tick(9);
                        #1;
                        chk("rd_pad", {1'b0, pad_out}, {1'b0, k ? rd_data : status_in});
                        chk("rd_oe", {1'b0, pad_oe}, 9'h0ff);
                        chk("rd_req", {8'h00, rd_req.is_data}, 9'(k));
                    end
                join
            end
        end
        straps <= STRAP_TWI;
        tick(12);
        d = 8'($urandom);
        exp_q.push_back({1'b1, d});
        u_dhif_host_model.twi({TWI_ADDR_HI, 1'b0, 1'b0, 1'b1, 8'h40, 1'b1, d, 1'b1});
        chk("oe_twi", {1'b0, pad_oe}, 9'h000);
        tick(20);
        chk("pending", 9'(exp_q.size()), 9'h000);
        chk("rd_reqs", 9'(rq_cnt), 9'h006);
        stop_test();
    end
endmodule // display_host_interface_front_end_tb_top
